// >>> hw/kef_pkg.sv
// Package for the key-event queue readout: register address, byte layout,
// reserved event codes and the event record carried into the queue.
// Assumes the command decoder of the serial port lives outside this block.
package kef_pkg;
   localparam logic [7:0] KEY_EVENT_QUEUE_ADDR = 8'h00;
   localparam int         KEY_W                = 6;
   localparam int         RELEASE_BIT          = 6;
   localparam int         MORE_BIT             = 7;
   localparam logic [5:0] CODE_ALL_ONES        = 6'h3f;
   localparam logic [5:0] CODE_REPEAT          = 6'h3e;
   localparam logic [5:0] KEY_HIGH_A           = 6'h3e;
   localparam logic [5:0] KEY_HIGH_B           = 6'h3f;
   localparam int         QUEUE_DEPTH          = 16;

   typedef enum logic [1:0] {
      EV_PRESS,
      EV_RELEASE,
      EV_REPEAT
   } kef_kind_t;

   typedef struct packed {
      kef_kind_t  kind;
      logic [5:0] key;
   } kef_event_t;
endpackage : kef_pkg

// >>> hw/kef_readout.sv
// Key-event queue with its host readout register.
// Assumes the debounce logic delivers one event per push pulse and the
// serial slave presents a one-cycle read strobe with the command address.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Low six bits hold key number.
// - Bit six set for release events.
// - Bit seven flags more queued events.
// - Overflow byte reported first, queue still readable.
// - Repeat code 111110, bit six means more.
// - Keys 62 and 63 always set bit seven.
// - Queue is one byte at address 0x00.
module kef_readout #(
   parameter int DEPTH = kef_pkg::QUEUE_DEPTH
) (
   // Clock and reset.
   input  wire logic               sys_clk,
   input  wire logic               reset,
   // Event source.
   input  wire logic               ev_push,
   input  wire kef_pkg::kef_event_t ev_data,
   // Host register read.
   input  wire logic               rd_strobe,
   input  wire logic [7:0]         rd_addr,
   output logic      [7:0]         rd_data_ff,
   output logic                    rd_valid_ff,
   // Status.
   output logic                    overflow_ff
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================================
   // Queue storage.
   kef_pkg::kef_event_t mem [DEPTH];
   logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   // The count is one bit wider than the pointers, so a full queue and an empty one differ.
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic          nxt_ovf;
   logic [7:0]    nxt_rd_data;
   logic          nxt_rd_valid;
   logic          pop, push_ok, full;
   kef_pkg::kef_event_t head;
   logic          more;
   logic          rd_hit;

   assign full    = (cnt_ff == (AW+1)'(DEPTH));
   assign head    = mem[rp_ff];
   assign more    = (cnt_ff > (AW+1)'(1));
   // Address match seen by the checks below; the read path decodes the strobe itself.
   assign rd_hit  = rd_strobe && (rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR);

   // The array has no reset: the count alone says which words are live,
   // so words left over from before a reset are never returned.
   always_ff @(posedge sys_clk) begin
      if (push_ok) begin
         mem[wp_ff] <= ev_data;
      end
   end

   // ==========================================================================
   // Read decode and byte formatting.
   always_comb begin
      logic hit;
      hit          = rd_strobe && (rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR);
      push_ok      = ev_push && !full;
      pop          = 1'b0;
      nxt_ovf      = overflow_ff;
      nxt_rd_valid = hit;
      nxt_rd_data  = rd_data_ff;
      if (hit) begin
         if (overflow_ff) begin
            // Overflow byte comes first; the stored events stay queued.
            nxt_rd_data = {1'b0, 1'b1, kef_pkg::CODE_ALL_ONES};
            nxt_ovf     = 1'b0;
         end else if (cnt_ff == '0) begin
            nxt_rd_data = {1'b0, 1'b0, kef_pkg::CODE_ALL_ONES};
         end else begin
            pop = 1'b1;
            unique case (head.kind)
               kef_pkg::EV_REPEAT:
                  nxt_rd_data = {1'b0, more, kef_pkg::CODE_REPEAT};
               default: begin
                  nxt_rd_data[kef_pkg::KEY_W-1:0]   = head.key;
                  nxt_rd_data[kef_pkg::RELEASE_BIT] = (head.kind == kef_pkg::EV_RELEASE);
                  // Keys 62 and 63 collide with reserved codes, so the host must reread.
                  nxt_rd_data[kef_pkg::MORE_BIT] = more
                     || head.key == kef_pkg::KEY_HIGH_A
                     || head.key == kef_pkg::KEY_HIGH_B;
               end
            endcase
         end
      end
      // A lost event wins over a clear in the same cycle.
      if (ev_push && full && !pop) begin
         nxt_ovf = 1'b1;
      end
      if (ev_push && full && pop) begin
         push_ok = 1'b1;
      end
      nxt_wp  = push_ok ? AW'(wp_ff + 1'b1) : wp_ff;
      nxt_rp  = pop ? AW'(rp_ff + 1'b1) : rp_ff;
      nxt_cnt = cnt_ff + (AW+1)'(push_ok) - (AW+1)'(pop);
   end

   // ==========================================================================
   // Registers.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wp_ff       <= '0;
         rp_ff       <= '0;
         cnt_ff      <= '0;
         overflow_ff <= 1'b0;
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         wp_ff       <= nxt_wp;
         rp_ff       <= nxt_rp;
         cnt_ff      <= nxt_cnt;
         overflow_ff <= nxt_ovf;
         rd_data_ff  <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   // ==========================================================================
   // Checks.
   a_empty_read_code: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && cnt_ff == '0 && !overflow_ff
      |=> rd_valid_ff && rd_data_ff == 8'h3f)
      else $error("empty queue read wrong byte");
   a_overflow_code: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && overflow_ff
      |=> rd_data_ff == 8'h7f && $stable(cnt_ff))
      else $error("overflow byte wrong");
   a_key_number: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && !overflow_ff && cnt_ff != '0
      && head.kind != kef_pkg::EV_REPEAT |=> rd_data_ff[5:0] == $past(head.key))
      else $error("key number wrong");
   a_release_flag: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && !overflow_ff && cnt_ff != '0
      && head.kind != kef_pkg::EV_REPEAT |=> rd_data_ff[6] == ($past(head.kind) == kef_pkg::EV_RELEASE))
      else $error("release flag wrong");
   a_more_flag: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && !overflow_ff && cnt_ff != '0
      && head.kind != kef_pkg::EV_REPEAT && head.key < 6'h3e |=> rd_data_ff[7] == $past(more))
      else $error("more flag wrong");
   a_repeat_code: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && !overflow_ff && cnt_ff != '0
      && head.kind == kef_pkg::EV_REPEAT |=> rd_data_ff == {1'b0, $past(more), 6'h3e})
      else $error("repeat byte wrong");
   a_high_keys: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr == kef_pkg::KEY_EVENT_QUEUE_ADDR && !overflow_ff && cnt_ff != '0
      && head.kind != kef_pkg::EV_REPEAT && head.key >= 6'h3e |=> rd_data_ff[7])
      else $error("high key lost bit seven");
   a_other_addr: assert property (@(posedge sys_clk) disable iff (reset)
      rd_strobe && rd_addr != kef_pkg::KEY_EVENT_QUEUE_ADDR |=> !rd_valid_ff && ($stable(cnt_ff) || $past(ev_push)))
      else $error("foreign address touched queue");

   // ==========================================================================
   // Checks on the read handshake.
   a_read_answer: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit |=> rd_valid_ff)
      else $error("accepted read gave no valid pulse");
   a_valid_single: assert property (@(posedge sys_clk) disable iff (reset)
      !rd_hit |=> !rd_valid_ff)
      else $error("valid pulse without a read");
   a_data_hold: assert property (@(posedge sys_clk) disable iff (reset)
      !rd_hit |=> $stable(rd_data_ff))
      else $error("read byte changed without a read");

   // ==========================================================================
   // Checks on the queue bookkeeping.
   // A push into a full queue is kept when the same cycle pops the head.
   a_full_swap: assert property (@(posedge sys_clk) disable iff (reset)
      ev_push && full && rd_hit && !overflow_ff
      |=> $stable(cnt_ff) && !overflow_ff)
      else $error("push beside a pop of a full queue was lost");
   // Any other push into a full queue is lost, and the mark wins over a clear.
   a_overflow_set: assert property (@(posedge sys_clk) disable iff (reset)
      ev_push && full && !(rd_hit && !overflow_ff)
      |=> overflow_ff && $stable(cnt_ff))
      else $error("lost event not flagged");
   a_overflow_keep: assert property (@(posedge sys_clk) disable iff (reset)
      overflow_ff && !rd_hit
      |=> overflow_ff)
      else $error("overflow mark dropped without a read");
   a_overflow_clear: assert property (@(posedge sys_clk) disable iff (reset)
      overflow_ff && rd_hit && !ev_push
      |=> !overflow_ff && rd_data_ff == 8'h7f)
      else $error("overflow byte read did not clear the mark");
   a_push_one: assert property (@(posedge sys_clk) disable iff (reset)
      ev_push && !full && !rd_hit
      |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("push did not raise the count");
   a_pop_one: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit && !overflow_ff && cnt_ff != '0 && !ev_push
      |=> cnt_ff == $past(cnt_ff) - 1'b1)
      else $error("read did not lower the count");
   a_count_bound: assert property (@(posedge sys_clk) disable iff (reset)
      cnt_ff <= (AW+1)'(DEPTH))
      else $error("count above the queue depth");
   a_empty_stays: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit && cnt_ff == '0 && !overflow_ff && !ev_push
      |=> cnt_ff == '0)
      else $error("read of an empty queue moved the count");

   // ==========================================================================
   // Checks on the byte layout that do not lean on the internal more flag.
   a_last_entry: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit && !overflow_ff && cnt_ff == (AW+1)'(1)
      && head.kind != kef_pkg::EV_REPEAT && head.key < kef_pkg::KEY_HIGH_A
      |=> !rd_data_ff[7])
      else $error("last entry claimed more data");
   a_repeat_more: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit && !overflow_ff && cnt_ff > (AW+1)'(1) && head.kind == kef_pkg::EV_REPEAT
      |=> rd_data_ff == 8'h7e)
      else $error("repeat with more data wrong");
   a_high_last: assert property (@(posedge sys_clk) disable iff (reset)
      rd_hit && !overflow_ff && cnt_ff == (AW+1)'(1)
      && head.kind != kef_pkg::EV_REPEAT && head.key >= kef_pkg::KEY_HIGH_A
      |=> rd_data_ff[7] && rd_data_ff[5:0] == $past(head.key))
      else $error("last high key byte wrong");
endmodule : kef_readout
`default_nettype wire

// >>> tb/kef_host_model.sv
// Host reader model for the key-event queue register.
// Assumes the bench calls read_reg from one process only.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host reads
module kef_host_model (
   // Clock.
   input  wire logic       sys_clk,
   // Read request.
   output logic            rd_strobe,
   output logic [7:0]      rd_addr,
   // Read answer.
   input  wire logic [7:0] rd_data_ff,
   input  wire logic       rd_valid_ff
);
   initial begin
      rd_strobe = 1'b0;
      rd_addr   = 8'hff;
   end
   // The address is inverted when idle so a stale value is never mistaken for a request.
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge sys_clk);
      rd_strobe <= 1'b1;
      rd_addr   <= a;
      @(posedge sys_clk);
      rd_strobe <= 1'b0;
      rd_addr   <= ~a;
      #1;
      v = rd_valid_ff;
      d = rd_data_ff;
   endtask : read_reg
endmodule : kef_host_model
`default_nettype wire

// >>> tb/tb_kef_readout.sv
// Self-checking bench for the key-event queue readout.
// Assumes the host model answers one read per call.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
// ==========
// Bench
module tb_kef_readout;
   logic                sys_clk = 1'b0;
   logic                reset   = 1'b1;
   logic                ev_push = 1'b0;
   kef_pkg::kef_event_t ev_data = '0;
   logic                rd_strobe, rd_valid_ff, overflow_ff, vld;
   logic [7:0]          rd_addr, rd_data_ff, d;
   int                  err_total = 0;
   int                  samples_checked = 0;
   always #25 sys_clk = ~sys_clk;
   kef_readout kef_readout_inst (.sys_clk(sys_clk), .reset(reset), .ev_push(ev_push), .ev_data(ev_data),
      .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
      .overflow_ff(overflow_ff));
   kef_host_model kef_host_model_inst (.sys_clk(sys_clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
      .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));
   task automatic push(input kef_pkg::kef_kind_t k, input logic [5:0] key);
      @(posedge sys_clk);
      ev_push <= 1'b1;
      ev_data <= kef_pkg::kef_event_t'{k, key};
      @(posedge sys_clk);
      ev_push <= 1'b0;
   endtask : push
   task automatic rd_chk(input logic [7:0] e);
      kef_host_model_inst.read_reg(8'h00, d, vld);
      `CHK(vld, 1'b1)
      `CHK(d, e)
   endtask : rd_chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd_chk(8'h3f);
      kef_host_model_inst.read_reg(8'h01, d, vld);
      `CHK(vld, 1'b0)
      `CHK(d, 8'h3f)
      push(kef_pkg::EV_PRESS, 6'h05);
      push(kef_pkg::EV_RELEASE, 6'h3e);
      push(kef_pkg::EV_PRESS, 6'h3f);
      push(kef_pkg::EV_REPEAT, 6'h3e);
      rd_chk(8'h85);
      rd_chk(8'hfe);
      rd_chk(8'hbf);
      rd_chk(8'h3e);
      rd_chk(8'h3f);
      // A repeat with more behind it, then high keys as the last entry.
      push(kef_pkg::EV_REPEAT, 6'h00);
      push(kef_pkg::EV_RELEASE, 6'h3e);
      rd_chk(8'h7e);
      rd_chk(8'hfe);
      rd_chk(8'h3f);
      push(kef_pkg::EV_RELEASE, 6'h3f);
      rd_chk(8'hff);
      rd_chk(8'h3f);
      // One push beyond the depth must be lost and flagged.
      for (int i = 0; i < 17; i++) push(kef_pkg::EV_PRESS, i[5:0]);
      // The flag settles after the edge that takes the last push.
      #1;
      `CHK(overflow_ff, 1'b1)
      rd_chk(8'h7f);
      `CHK(overflow_ff, 1'b0)
      for (int i = 0; i < 16; i++) rd_chk({i < 15, 1'b0, i[5:0]});
      rd_chk(8'h3f);
      // A push into a full queue beside a pop is kept behind the others.
      for (int i = 0; i < 16; i++) push(kef_pkg::EV_PRESS, i[5:0]);
      fork
         push(kef_pkg::EV_PRESS, 6'h14);
         rd_chk(8'h80);
      join
      `CHK(overflow_ff, 1'b0)
      for (int i = 1; i < 16; i++) rd_chk({1'b1, 1'b0, i[5:0]});
      rd_chk(8'h14);
      // A reset in mid-run empties the queue.
      push(kef_pkg::EV_PRESS, 6'h07);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd_chk(8'h3f);
      complete_run();
   end
endmodule : tb_kef_readout
`default_nettype wire
